// ===== rxptr_defs.svh
// register offsets, field positions and widths for the rx pointer / irq clear block
// assumes a 32-bit apb slave whose paddr carries byte addresses within the mac window
`ifndef RXPTR_DEFS_SVH
`define RXPTR_DEFS_SVH
`define OFF_IRQ_CLEAR       16'hC020
`define OFF_RX_FRAME_RD     16'hC024
`define OFF_RX_FRAME_WR     16'hC028
`define OFF_RX_DESC_RD      16'hC02C
`define OFF_RX_DESC_WR      16'hC030
`define OFF_RX_COMMAND      16'hC010
`define OFF_RX_STATUS       16'hC004
`define BIT_CLR_TX          0
`define BIT_CLR_RX          4
`define FRAME_PTR_W         12
`define DESC_PTR_W          6
`define UNREAD_W            6
`define UNREAD_LSB          1
`endif

// ===== rxptr_pkg.sv
// types shared by the rx pointer block
// assumes rxptr_defs.svh is available to the files that use numeric constants
package rxptr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_ACCESS = 3'b010,
		ST_DONE   = 3'b100
	} apb_state_e;
endpackage

// ===== ptr_bus_if.sv
// carrier between the top and one of its pointer counters
// assumes both ends share pclk
interface ptr_bus_if #(parameter int W = 12);
	logic         adv;
	logic [W:0]   value;
	modport owner (output adv, input value);
	modport ctr   (input adv, output value);
endinterface

// ===== wrap_ptr.sv
// one wrapping pointer with a rollover bit above its address field
// assumes adv is a single-cycle advance request synchronous to pclk
module wrap_ptr #(
	parameter int W = 12
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pce,
	ptr_bus_if.ctr    bus
);
	logic [W:0] ptr_r;
	logic [W:0] ptr_nxt;

	// carry out of the address field lands in the rollover bit, so it toggles on wrap
	assign ptr_nxt = ptr_r + {{W{1'b0}}, 1'b1};
	assign bus.value = ptr_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ptr_r <= '0;
		else if (pce && bus.adv)
			ptr_r <= ptr_nxt;
	end
endmodule

// ===== rx_ptr_regs.sv
// apb register slice: interrupt clear and the four receive pointer registers
// assumes the mac's rx engine pulses its advance strobes and raises its irq events synchronous to pclk
//
// Summary of operation
// [R1] writing one to bit 0 clears tx interrupt
// [R2] writing one to bit 4 clears rx interrupt
// [R3] zero in a clear bit leaves interrupt pending
// [R4] frame read pointer 11:0, rollover bit 12
// [R5] frame write pointer 11:0, rollover bit 12
// [R6] descriptor read pointer 5:0, rollover bit 6
// [R7] descriptor write pointer 5:0, rollover bit 6
// [R8] an rx command write decrements unread count, floored at zero; a new frame in the same cycle cancels it
// [R9] equal pointers and rollovers mean empty, equal pointers with differing rollovers mean full
`include "rxptr_defs.svh"
module rx_ptr_regs #(
	parameter int FW = `FRAME_PTR_W,
	parameter int DW = `DESC_PTR_W,
	parameter int UW = `UNREAD_W
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_irq_event,
	input  wire logic        rx_irq_event,
	input  wire logic        frame_rd_adv,
	input  wire logic        frame_wr_adv,
	input  wire logic        desc_rd_adv,
	input  wire logic        desc_wr_adv,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic      [UW-1:0] unread_count
);
	rxptr_pkg::apb_state_e state_r;
	rxptr_pkg::apb_state_e state_nxt;
	logic [31:0] prdata_nxt;
	logic [UW-1:0] unread_nxt;

	ptr_bus_if #(.W(FW)) frd_bus ();
	ptr_bus_if #(.W(FW)) fwr_bus ();
	ptr_bus_if #(.W(DW)) drd_bus ();
	ptr_bus_if #(.W(DW)) dwr_bus ();

	assign frd_bus.adv = frame_rd_adv;
	assign fwr_bus.adv = frame_wr_adv;
	assign drd_bus.adv = desc_rd_adv;
	assign dwr_bus.adv = desc_wr_adv;

	wrap_ptr #(.W(FW)) u_frame_rd (.pclk(pclk), .presetn(presetn), .pce(pce), .bus(frd_bus)); // see [R4]
	wrap_ptr #(.W(FW)) u_frame_wr (.pclk(pclk), .presetn(presetn), .pce(pce), .bus(fwr_bus)); // see [R5]
	wrap_ptr #(.W(DW)) u_desc_rd  (.pclk(pclk), .presetn(presetn), .pce(pce), .bus(drd_bus)); // see [R6]
	wrap_ptr #(.W(DW)) u_desc_wr  (.pclk(pclk), .presetn(presetn), .pce(pce), .bus(dwr_bus)); // see [R7]

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	// the transfer completes at the access cycle after setup with no wait state; read data is registered at the setup edge
	wire setup_w  = psel && !penable;
	wire commit_w = (state_r == rxptr_pkg::ST_ACCESS) && psel && penable;
	wire wr_w     = commit_w && pwrite;
	wire sel_clr  = hit(paddr, `OFF_IRQ_CLEAR);
	wire sel_frd  = hit(paddr, `OFF_RX_FRAME_RD);
	wire sel_fwr  = hit(paddr, `OFF_RX_FRAME_WR);
	wire sel_drd  = hit(paddr, `OFF_RX_DESC_RD);
	wire sel_dwr  = hit(paddr, `OFF_RX_DESC_WR);
	wire sel_cmd  = hit(paddr, `OFF_RX_COMMAND);
	wire sel_st   = hit(paddr, `OFF_RX_STATUS);
	wire mapped_w = sel_clr | sel_frd | sel_fwr | sel_drd | sel_dwr | sel_cmd | sel_st;
	// pointers are read-only and clear/command are write-only; wrong direction is an error
	wire legal_w  = pwrite ? (sel_clr | sel_cmd) : (sel_frd | sel_fwr | sel_drd | sel_dwr | sel_st);

	wire clr_tx_w = wr_w && sel_clr && pwdata[`BIT_CLR_TX]; // see [R1] [R3]
	wire clr_rx_w = wr_w && sel_clr && pwdata[`BIT_CLR_RX]; // see [R2] [R3]
	wire rx_done_w = wr_w && sel_cmd; // see [R8]
	wire rx_new_w  = frame_wr_adv;

	// an arriving event beats a clear in the same cycle
	wire tx_irq_nxt = tx_irq_event | (tx_irq & ~clr_tx_w);
	wire rx_irq_nxt = rx_irq_event | (rx_irq & ~clr_rx_w);

	always_comb begin
		unread_nxt = unread_count;
		if (rx_new_w && !rx_done_w && unread_count != {UW{1'b1}})
			unread_nxt = unread_count + {{(UW-1){1'b0}}, 1'b1};
		else if (rx_done_w && !rx_new_w && unread_count != '0)
			unread_nxt = unread_count - {{(UW-1){1'b0}}, 1'b1}; // see [R8]
	end

	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (sel_frd)
			prdata_nxt[FW:0] = frd_bus.value;
		else if (sel_fwr)
			prdata_nxt[FW:0] = fwr_bus.value;
		else if (sel_drd)
			prdata_nxt[DW:0] = drd_bus.value;
		else if (sel_dwr)
			prdata_nxt[DW:0] = dwr_bus.value;
		else if (sel_st)
			prdata_nxt[`UNREAD_LSB +: UW] = unread_count;
	end

	always_comb begin
		case (state_r)
			rxptr_pkg::ST_IDLE:   state_nxt = setup_w ? rxptr_pkg::ST_ACCESS : rxptr_pkg::ST_IDLE;
			rxptr_pkg::ST_ACCESS: state_nxt = commit_w ? rxptr_pkg::ST_DONE : rxptr_pkg::ST_ACCESS;
			rxptr_pkg::ST_DONE:   state_nxt = setup_w ? rxptr_pkg::ST_ACCESS : rxptr_pkg::ST_IDLE;
			default:              state_nxt = rxptr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= rxptr_pkg::ST_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (pce) begin
			state_r <= state_nxt;
			pready  <= setup_w;
			pslverr <= setup_w && !(mapped_w && legal_w);
			prdata  <= (setup_w && !pwrite) ? prdata_nxt : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq       <= 1'b0;
			rx_irq       <= 1'b0;
			unread_count <= '0;
		end else if (pce) begin
			tx_irq       <= tx_irq_nxt; // see [R1]
			rx_irq       <= rx_irq_nxt; // see [R2]
			unread_count <= unread_nxt;
		end
	end

	a_tx_clear_one: assert property (@(posedge pclk) disable iff (!presetn) // see [R1]
		(pce && clr_tx_w && !tx_irq_event) |=> !tx_irq)
		else $error("tx interrupt not cleared");
	a_rx_clear_one: assert property (@(posedge pclk) disable iff (!presetn) // see [R2]
		(pce && clr_rx_w && !rx_irq_event) |=> !rx_irq)
		else $error("rx interrupt not cleared");
	a_zero_keeps_irq: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
		(pce && wr_w && sel_clr && !pwdata[`BIT_CLR_TX] && tx_irq) |=> tx_irq)
		else $error("tx interrupt lost on zero write");
	a_frame_rd_wrap: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
		(pce && frame_rd_adv && frd_bus.value[FW-1:0] == {FW{1'b1}})
		|=> frd_bus.value[FW] != $past(frd_bus.value[FW]) && frd_bus.value[FW-1:0] == '0)
		else $error("frame read rollover wrong");
	a_frame_wr_step: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
		(pce && frame_wr_adv) |=> fwr_bus.value == $past(fwr_bus.value) + 13'h0001)
		else $error("frame write pointer step wrong");
	a_desc_rd_wrap: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
		(pce && desc_rd_adv && drd_bus.value[DW-1:0] == {DW{1'b1}})
		|=> drd_bus.value[DW] != $past(drd_bus.value[DW]))
		else $error("desc read rollover wrong");
	a_desc_wr_hold: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
		(!desc_wr_adv || !pce) |=> $stable(dwr_bus.value))
		else $error("desc write pointer moved unasked");
	sequence s_cmd_write;
		pce && rx_done_w && !rx_new_w && unread_count != '0;
	endsequence
	a_unread_dec: assert property (@(posedge pclk) disable iff (!presetn) // see [R8]
		s_cmd_write |=> unread_count == $past(unread_count) - 6'h01)
		else $error("unread count not decremented");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && setup_w) |=> pready ##1 !pready)
		else $error("pready not one cycle");

	// bus answer: one pulse per setup, with the error flag and the read data riding on it
	sequence s_setup;
		pce && setup_w;
	endsequence
	sequence s_read_setup(sel);
		pce && setup_w && !pwrite && sel;
	endsequence
	sequence s_answer(bad);
		pready && (pslverr == bad);
	endsequence
	a_ready_follows_setup: assert property (@(posedge pclk) disable iff (!presetn)
		pce |=> pready == $past(setup_w))
		else $error("pready not tied to setup");
	a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("pslverr without pready");
	a_idle_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside an answer");
	a_write_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(s_setup ##0 pwrite) |=> prdata == 32'h0000_0000)
		else $error("prdata not zero on a write");
	a_state_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(state_r))
		else $error("apb state not one-hot");
	a_commit_in_answer: assert property (@(posedge pclk) disable iff (!presetn)
		commit_w |-> pready)
		else $error("commit outside the answer cycle");
	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(s_setup ##0 !mapped_w) |=> s_answer(1'b1))
		else $error("unmapped address not refused");
	a_direction_error: assert property (@(posedge pclk) disable iff (!presetn)
		(s_setup ##0 (mapped_w && !legal_w)) |=> s_answer(1'b1))
		else $error("wrong direction not refused");
	a_legal_no_error: assert property (@(posedge pclk) disable iff (!presetn)
		(s_setup ##0 (mapped_w && legal_w)) |=> s_answer(1'b0))
		else $error("legal access refused");
	a_read_frame_rd: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
		s_read_setup(sel_frd) |=> s_answer(1'b0) ##0 prdata == 32'($past(frd_bus.value)))
		else $error("frame read pointer read back wrong");
	a_read_frame_wr: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
		s_read_setup(sel_fwr) |=> s_answer(1'b0) ##0 prdata == 32'($past(fwr_bus.value)))
		else $error("frame write pointer read back wrong");
	a_read_desc_rd: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
		s_read_setup(sel_drd) |=> s_answer(1'b0) ##0 prdata == 32'($past(drd_bus.value)))
		else $error("desc read pointer read back wrong");
	a_read_desc_wr: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
		s_read_setup(sel_dwr) |=> s_answer(1'b0) ##0 prdata == 32'($past(dwr_bus.value)))
		else $error("desc write pointer read back wrong");
	a_read_status: assert property (@(posedge pclk) disable iff (!presetn) // see [R8]
		s_read_setup(sel_st) |=> s_answer(1'b0) ##0 prdata[`UNREAD_LSB +: UW] == $past(unread_count))
		else $error("status read back wrong");

	// interrupt flags: an event always wins, and only the matching clear bit drops a flag
	a_tx_event_sets: assert property (@(posedge pclk) disable iff (!presetn) // see [R1]
		(pce && tx_irq_event) |=> tx_irq)
		else $error("tx event lost");
	a_rx_event_sets: assert property (@(posedge pclk) disable iff (!presetn) // see [R2]
		(pce && rx_irq_event) |=> rx_irq)
		else $error("rx event lost");
	a_rx_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
		(pce && wr_w && sel_clr && !pwdata[`BIT_CLR_RX] && rx_irq) |=> rx_irq)
		else $error("rx interrupt lost on zero write");
	a_tx_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && !tx_irq_event && !tx_irq) |=> !tx_irq)
		else $error("tx interrupt raised without event");
	a_rx_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && !rx_irq_event && !rx_irq) |=> !rx_irq)
		else $error("rx interrupt raised without event");
	a_tx_kept_elsewhere: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && wr_w && !sel_clr && tx_irq) |=> tx_irq)
		else $error("tx interrupt lost on another write");

	// pointers: one step per strobe, nothing without one, and writes never move them
	a_frame_rd_step: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
		(pce && frame_rd_adv) |=> frd_bus.value == $past(frd_bus.value) + 1'b1)
		else $error("frame read pointer step wrong");
	a_frame_rd_hold: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
		(!frame_rd_adv || !pce) |=> $stable(frd_bus.value))
		else $error("frame read pointer moved unasked");
	a_frame_wr_wrap: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
		(pce && frame_wr_adv && fwr_bus.value[FW-1:0] == {FW{1'b1}})
		|=> fwr_bus.value[FW] != $past(fwr_bus.value[FW]) && fwr_bus.value[FW-1:0] == '0)
		else $error("frame write rollover wrong");
	a_frame_wr_hold: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
		(!frame_wr_adv || !pce) |=> $stable(fwr_bus.value))
		else $error("frame write pointer moved unasked");
	a_desc_rd_step: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
		(pce && desc_rd_adv) |=> drd_bus.value == $past(drd_bus.value) + 1'b1)
		else $error("desc read pointer step wrong");
	a_desc_rd_ro: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
		(pce && wr_w && sel_drd && !desc_rd_adv) |=> $stable(drd_bus.value))
		else $error("desc read pointer moved by a write");
	a_desc_wr_step: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
		(pce && desc_wr_adv) |=> dwr_bus.value == $past(dwr_bus.value) + 1'b1)
		else $error("desc write pointer step wrong");
	a_desc_wr_wrap: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
		(pce && desc_wr_adv && dwr_bus.value[DW-1:0] == {DW{1'b1}})
		|=> dwr_bus.value[DW] != $past(dwr_bus.value[DW]) && dwr_bus.value[DW-1:0] == '0)
		else $error("desc write rollover wrong");

	// unread count: saturating up on a new frame, down on a command write, still when both land
	sequence s_new_frame_only;
		pce && rx_new_w && !rx_done_w;
	endsequence
	a_unread_inc: assert property (@(posedge pclk) disable iff (!presetn)
		(s_new_frame_only ##0 unread_count != {UW{1'b1}}) |=> unread_count == $past(unread_count) + 1'b1)
		else $error("unread count not incremented");
	a_unread_ceiling: assert property (@(posedge pclk) disable iff (!presetn)
		(s_new_frame_only ##0 unread_count == {UW{1'b1}}) |=> unread_count == {UW{1'b1}})
		else $error("unread count wrapped at the top");
	a_unread_floor: assert property (@(posedge pclk) disable iff (!presetn) // see [R8]
		(pce && rx_done_w && !rx_new_w && unread_count == '0) |=> unread_count == '0)
		else $error("unread count wrapped at zero");
	a_unread_cancel: assert property (@(posedge pclk) disable iff (!presetn) // see [R8]
		(pce && rx_done_w && rx_new_w) |=> $stable(unread_count))
		else $error("unread count moved on new frame plus command");
	a_unread_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && !rx_done_w && !rx_new_w) |=> $stable(unread_count))
		else $error("unread count moved unasked");

	// clock enable low: every register holds, so strobes seen then are lost, not queued
	a_freeze_flags: assert property (@(posedge pclk) disable iff (!presetn)
		!pce |=> $stable(tx_irq) && $stable(rx_irq) && $stable(unread_count))
		else $error("flags moved while frozen");
	a_freeze_bus: assert property (@(posedge pclk) disable iff (!presetn)
		!pce |=> $stable(pready) && $stable(pslverr) && $stable(prdata) && $stable(state_r))
		else $error("bus side moved while frozen");
	a_freeze_ptrs: assert property (@(posedge pclk) disable iff (!presetn)
		!pce |=> $stable(frd_bus.value) && $stable(fwr_bus.value) && $stable(drd_bus.value))
		else $error("pointer moved while frozen");
endmodule

// ===== tb_rx_ptr_regs.sv
// self-checking bench for the rx pointer and interrupt clear register slice
// assumes rxptr_defs.svh is on the include path; apb answers are awaited, never counted
`include "rxptr_defs.svh"
module tb_rx_ptr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        pce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  ev;
	logic        tx_irq;
	logic        rx_irq;
	logic [5:0]  unread_count;
	int          bad_count;
	int          n_tests;
	logic [31:0] rd;
	logic        err;

	rx_ptr_regs dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_irq_event(ev[0]), .rx_irq_event(ev[1]), .frame_rd_adv(ev[2]),
		.frame_wr_adv(ev[3]), .desc_rd_adv(ev[4]), .desc_wr_adv(ev[5]), .tx_irq(tx_irq),
		.rx_irq(rx_irq), .unread_count(unread_count));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// the answer is read in the time step of the edge that samples pready, before that edge's updates land
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [5:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 6'h00;
	endtask

	task automatic clr_irq(input logic [31:0] d, input logic [1:0] exp);
		apb(1'b1, `OFF_IRQ_CLEAR, d);
		repeat (2) @(negedge pclk);
		chk({30'h0, rx_irq, tx_irq}, {30'h0, exp});
	endtask

	// software reads each pair as empty after reset: equal address and rollover
	task automatic t_reset_vals();
		logic [31:0] rp;
		apb(1'b0, `OFF_RX_FRAME_RD, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h0);
		rp = rd;
		apb(1'b0, `OFF_RX_FRAME_WR, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, rd == rp}, 32'h1);
		apb(1'b0, `OFF_RX_DESC_RD, 32'h0);
		chk(rd, 32'h0);
		rp = rd;
		apb(1'b0, `OFF_RX_DESC_WR, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, rd == rp}, 32'h1);
	endtask

	task automatic t_irq_clear();
		pulse(6'h03);
		clr_irq(32'hFFFFFFEE, 2'b11);
		clr_irq(32'h00000001, 2'b10);
		clr_irq(32'h00000010, 2'b00);
	endtask

	// counts land on each wrap and one past it to catch a rollover bit that toggles late
	task automatic t_wrap();
		int i;
		for (i = 0; i < 4097; i++)
			pulse({i < 65, i < 64, 1'b1, i < 4096, 2'b00});
		apb(1'b0, `OFF_RX_FRAME_RD, 32'h0);
		chk(rd, 32'h00001000);
		apb(1'b0, `OFF_RX_FRAME_WR, 32'h0);
		chk(rd, 32'h00001001);
		apb(1'b0, `OFF_RX_DESC_RD, 32'h0);
		chk(rd, 32'h00000040);
		apb(1'b0, `OFF_RX_DESC_WR, 32'h0);
		chk(rd, 32'h00000041);
		apb(1'b1, `OFF_RX_DESC_RD, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, `OFF_RX_DESC_RD, 32'h0);
		chk(rd, 32'h00000040);
		apb(1'b0, 16'hC040, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask

	// events and strobes that arrive while frozen are dropped, not queued
	task automatic t_freeze();
		@(posedge pclk);
		pce <= 1'b0;
		pulse(6'h05);
		@(posedge pclk);
		pce <= 1'b1;
		chk({30'h0, rx_irq, tx_irq}, 32'h0);
		apb(1'b0, `OFF_RX_FRAME_RD, 32'h0);
		chk(rd, 32'h00001000);
	endtask

	task automatic t_unread();
		chk({26'h0, unread_count}, 32'h3F);
		apb(1'b1, `OFF_RX_COMMAND, 32'hA5A5A5A5);
		repeat (2) @(negedge pclk);
		chk({26'h0, unread_count}, 32'h3E);
		apb(1'b0, `OFF_RX_STATUS, 32'h0);
		chk(rd, 32'h0000007C);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		end_sim();
	end

	initial begin
		bad_count = 0;
		n_tests = 0;
		presetn = 1'b0;
		pce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		ev = 6'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk({30'h0, rx_irq, tx_irq}, 32'h0);
		t_reset_vals();
		t_irq_clear();
		t_wrap();
		t_freeze();
		t_unread();
		end_sim();
	end
endmodule
